// ==== hw/tdba_defines.svh ====
`ifndef TDBA_DEFINES_SVH
`define TDBA_DEFINES_SVH
// register byte offsets
`define TDBA_OFF_CFG 8'h48
`define TDBA_OFF_BUF 8'h4c
`define TDBA_OFF_OPT 8'hfc
`define TDBA_OFF_CCHP 8'h44
`define TDBA_OFF_CV0 8'h34
`define TDBA_OFF_CV3 8'h40
// field positions and shared constants
`define TDBA_START_HI 4
`define TDBA_START_LO 0
`define TDBA_COUNT_HI 12
`define TDBA_COUNT_LO 8
`define TDBA_FILT_BIT 1
`define TDBA_FDIS_BIT 0
`define TDBA_PRIMARY_OUTPUT_ENABLE_BIT 15
`define TDBA_IOS_BIT 10
`define TDBA_COUNT_MAX 5'h11
`define TDBA_ZERO32 32'h00000000
`define TDBA_ZERO5 5'h00
`define TDBA_ONE5 5'h01
`define TDBA_ONE6 6'h01
`define TDBA_CCHP_RD_MASK 32'h0000ffff
`define TDBA_HTRANS_NSEQ 2'h2
`endif

// ==== hw/tdba_pkg.sv ====
package tdba_pkg;
  // address phase captured for the data phase
  typedef struct packed {
    logic act;
    logic wr;
    logic [7:0] addr;
  } tdba_aphase_t;
  // bus slave state
  typedef enum logic [0:0] {
    TDBA_IDLE = 1'b0,
    TDBA_DATA = 1'b1
  } tdba_state_t;
endpackage

// ==== hw/timer_dma_burst_access.sv ====
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tdba_defines.svh"
module tdba_timer_dma_burst_access (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // channel output control
  input wire logic [3:0] chanEnable,
  output logic [3:0] chanOutEnable,
  output logic [3:0] chanOffState,
  output logic outputsForcedOff
);
  // captured address phase
  tdba_pkg::tdba_aphase_t aph_reg;
  tdba_pkg::tdba_state_t state_reg;
  // burst configuration fields
  logic [4:0] burstStartIndex_reg;
  logic [4:0] burstCount_reg;
  logic [4:0] xferIndex_reg;
  // index of the register most recently reached through the buffer
  logic [4:0] reachedIndex_reg;
  // option bits
  logic sameValueWriteFilter_reg;
  logic forcedOutputDisableSelect_reg;
  // protection register stand-in and compare values
  logic [15:0] cchp_reg;
  logic [15:0] compareValue_reg [0:3];
  logic [31:0] hrdata_reg;
  // effective target of this data phase
  logic [7:0] tgtAddr;
  logic isBuf;
  logic [7:0] burstAddr;
  logic wrEn;
  // configuration write in this data phase
  logic cfgWrite;
  // buffer access whose data phase ends at this edge
  logic bufDone;
  // read data taken in the wait cycle, before the phase ends
  logic readCapture;
  logic [31:0] rdValue;
  logic primaryOutputEnable;
  logic idleOffStateEnable;

  assign primaryOutputEnable = cchp_reg[`TDBA_PRIMARY_OUTPUT_ENABLE_BIT];
  assign idleOffStateEnable = cchp_reg[`TDBA_IOS_BIT];

  // burst window address: four times the sum of start and index
  assign burstAddr = 8'((burstStartIndex_reg + xferIndex_reg) << 2);
  assign isBuf = aph_reg.act && (aph_reg.addr == `TDBA_OFF_BUF);
  assign tgtAddr = isBuf ? burstAddr : aph_reg.addr;
  assign wrEn = aph_reg.act && aph_reg.wr;
  assign cfgWrite = wrEn && (aph_reg.addr == `TDBA_OFF_CFG);
  // a read phase spans two cycles, so step only where it ends
  assign bufDone = isBuf && hready;
  assign readCapture = aph_reg.act && !aph_reg.wr && !hready;

  // address phase capture; one wait state on reads, word transfers only assumed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aph_reg <= '0;
      state_reg <= tdba_pkg::TDBA_IDLE;
    end else if (hready) begin
      aph_reg.act <= hsel && (htrans == `TDBA_HTRANS_NSEQ);
      aph_reg.wr <= hwrite;
      aph_reg.addr <= haddr[7:0];
      state_reg <= (hsel && htrans == `TDBA_HTRANS_NSEQ) ? tdba_pkg::TDBA_DATA
                                                        : tdba_pkg::TDBA_IDLE;
    end
  end

  // burst configuration register writes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      burstStartIndex_reg <= `TDBA_ZERO5;
      burstCount_reg <= `TDBA_ZERO5;
    end else if (wrEn && aph_reg.addr == `TDBA_OFF_CFG) begin
      // reserved bits dropped, host writes them zero
      burstStartIndex_reg <= hwdata[`TDBA_START_HI:`TDBA_START_LO];
      burstCount_reg <= hwdata[`TDBA_COUNT_HI:`TDBA_COUNT_LO];
    end
  end

  // transfer index walk
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xferIndex_reg <= `TDBA_ZERO5;
    end else if (wrEn && aph_reg.addr == `TDBA_OFF_CFG) begin
      // new configuration restarts the burst
      xferIndex_reg <= `TDBA_ZERO5;
    end else if (bufDone) begin
      if (xferIndex_reg >= burstCount_reg) begin
        xferIndex_reg <= `TDBA_ZERO5;
      end else begin
        xferIndex_reg <= xferIndex_reg + `TDBA_ONE5;
      end
    end
  end

  // register just reached; the walk itself keeps the programmed start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reachedIndex_reg <= `TDBA_ZERO5;
    end else if (cfgWrite) begin
      // before any access the field shows the start
      reachedIndex_reg <= hwdata[`TDBA_START_HI:`TDBA_START_LO];
    end else if (bufDone) begin
      // wraps past the last index like the address field
      reachedIndex_reg <= 5'(burstStartIndex_reg + xferIndex_reg);
    end
  end

  // option register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sameValueWriteFilter_reg <= 1'b0;
      forcedOutputDisableSelect_reg <= 1'b0;
    end else if (wrEn && aph_reg.addr == `TDBA_OFF_OPT) begin
      sameValueWriteFilter_reg <= hwdata[`TDBA_FILT_BIT];
      forcedOutputDisableSelect_reg <= hwdata[`TDBA_FDIS_BIT];
    end
  end

  // output protection register, reachable directly or by burst
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cchp_reg <= 16'h0000;
    end else if (wrEn && tgtAddr == `TDBA_OFF_CCHP) begin
      cchp_reg <= hwdata[15:0];
    end
  end

  // compare value registers, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gCmp
      localparam logic [7:0] CMP_ADDR = 8'(`TDBA_OFF_CV0 + 4 * gi);
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          compareValue_reg[gi] <= 16'h0000;
        end else if (wrEn && tgtAddr == CMP_ADDR) begin
          // same-value write discarded when filter set
          if (!(sameValueWriteFilter_reg && hwdata[15:0] == compareValue_reg[gi])) begin
            compareValue_reg[gi] <= hwdata[15:0];
          end
        end
      end
      // channel output gating
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          chanOutEnable[gi] <= 1'b0;
          chanOffState[gi] <= 1'b0;
        end else if (forcedOutputDisableSelect_reg && !primaryOutputEnable &&
                     !idleOffStateEnable) begin
          chanOutEnable[gi] <= 1'b0;
          chanOffState[gi] <= 1'b0;
        end else if (primaryOutputEnable) begin
          chanOutEnable[gi] <= chanEnable[gi];
          chanOffState[gi] <= 1'b0;
        end else begin
          // idle mode: off-state if enabled, else disabled
          chanOutEnable[gi] <= 1'b0;
          chanOffState[gi] <= idleOffStateEnable;
        end
      end
    end
  endgenerate

  // forced disable indicator
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      outputsForcedOff <= 1'b0;
    end else begin
      outputsForcedOff <= forcedOutputDisableSelect_reg && !primaryOutputEnable &&
                          !idleOffStateEnable;
    end
  end

  // read mux for the addressed register
  always_comb begin
    rdValue = `TDBA_ZERO32;
    case (tgtAddr)
      `TDBA_OFF_CFG: begin
        // start field shows the register just reached
        rdValue[`TDBA_START_HI:`TDBA_START_LO] = reachedIndex_reg;
        rdValue[`TDBA_COUNT_HI:`TDBA_COUNT_LO] = burstCount_reg;
      end
      `TDBA_OFF_OPT: begin
        rdValue[`TDBA_FILT_BIT] = sameValueWriteFilter_reg;
        rdValue[`TDBA_FDIS_BIT] = forcedOutputDisableSelect_reg;
      end
      `TDBA_OFF_CCHP: begin
        rdValue[15:0] = cchp_reg;
      end
      default: begin
        if (tgtAddr >= `TDBA_OFF_CV0 && tgtAddr <= `TDBA_OFF_CV3 && tgtAddr[1:0] == 2'h0) begin
          rdValue[15:0] = compareValue_reg[2'((tgtAddr - `TDBA_OFF_CV0) >> 2)];
        end
      end
    endcase
  end

  // registered read data: appears one cycle after the address phase edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_reg <= `TDBA_ZERO32;
    end else if (readCapture) begin
      // taken in the wait cycle, before the index steps
      hrdata_reg <= rdValue;
    end
  end

  // ready and response; one wait state on reads so hrdata comes from a flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      // low for the one wait cycle of a read, high otherwise
      hreadyout <= !(hsel && hready && htrans == `TDBA_HTRANS_NSEQ && !hwrite);
    end
  end
  assign hrdata = hrdata_reg;

  // assertions
  a_index_bound: assert property (@(posedge mclk) disable iff (!reset_n)
    (burstCount_reg <= `TDBA_COUNT_MAX) |-> (xferIndex_reg <= burstCount_reg))
    else $error("transfer index beyond count");
  a_index_step: assert property (@(posedge mclk) disable iff (!reset_n)
    (bufDone && !cfgWrite && xferIndex_reg < burstCount_reg)
    |=> (xferIndex_reg == $past(xferIndex_reg) + `TDBA_ONE5))
    else $error("index did not step");
  a_index_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    (bufDone && xferIndex_reg >= burstCount_reg) |=> (xferIndex_reg == `TDBA_ZERO5))
    else $error("index did not wrap");
  a_redirect_addr: assert property (@(posedge mclk) disable iff (!reset_n)
    isBuf |-> (tgtAddr == 8'((burstStartIndex_reg + xferIndex_reg) * 4)))
    else $error("buffer redirect wrong");
  a_filter_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrEn && sameValueWriteFilter_reg && tgtAddr == `TDBA_OFF_CV0 &&
     hwdata[15:0] == compareValue_reg[0]) |=> $stable(compareValue_reg[0]))
    else $error("same value write not dropped");
  a_write_takes: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrEn && !sameValueWriteFilter_reg && tgtAddr == `TDBA_OFF_CV0)
    |=> (compareValue_reg[0] == $past(hwdata[15:0])))
    else $error("compare write lost");
  a_forced_off: assert property (@(posedge mclk) disable iff (!reset_n)
    (forcedOutputDisableSelect_reg && !primaryOutputEnable && !idleOffStateEnable)
    |=> (outputsForcedOff && chanOutEnable == 4'h0 && chanOffState == 4'h0))
    else $error("outputs not forced off");
  a_primary_output_enable_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !primaryOutputEnable |=> (chanOutEnable == 4'h0))
    else $error("outputs on without primary enable");
  a_start_cfg: assert property (@(posedge mclk) disable iff (!reset_n)
    (wrEn && aph_reg.addr == `TDBA_OFF_CFG) |=> (xferIndex_reg == `TDBA_ZERO5 &&
     burstStartIndex_reg == $past(hwdata[4:0])))
    else $error("config write not applied");
  // start field follows each completed buffer access
  a_reached_index: assert property (@(posedge mclk) disable iff (!reset_n)
    (bufDone && !cfgWrite) |=> (reachedIndex_reg ==
     5'($past(burstStartIndex_reg) + $past(xferIndex_reg))))
    else $error("reached register not reported");
  // a read address phase always costs one wait cycle
  a_read_stall: assert property (@(posedge mclk) disable iff (!reset_n)
    (hsel && hready && htrans == `TDBA_HTRANS_NSEQ && !hwrite) |=> !hreadyout)
    else $error("read not stalled");
  // the wait cycle lasts exactly one clock
  a_read_wait: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_reg == tdba_pkg::TDBA_DATA && !aph_reg.wr && !hreadyout) |=> hreadyout)
    else $error("read wait too long");
  // writes finish with no wait
  a_write_nowait: assert property (@(posedge mclk) disable iff (!reset_n)
    (hsel && hready && htrans == `TDBA_HTRANS_NSEQ && hwrite) |=> hreadyout)
    else $error("write stalled");
  // read data stands until the next read
  a_rdata_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !readCapture |=> $stable(hrdata_reg))
    else $error("read data changed");
  // with primary enable set the outputs follow the channel enables
  a_out_follow: assert property (@(posedge mclk) disable iff (!reset_n)
    primaryOutputEnable |=> (chanOutEnable == $past(chanEnable)))
    else $error("outputs do not follow enables");
endmodule

// ==== tb/tdba_ahb_host.sv ====
`timescale 1ns/1ps
module tdba_ahb_host (
  // clock
  input wire logic mclk,
  // ahb-lite master outputs
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // quiet bus at time zero
  initial begin
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
  end
  // one single transfer, held until hready is sampled high
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2; // whole word only
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= d; // callers keep reserved bits zero
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// ==== tb/timer_dma_burst_access_tb_top.sv ====
`timescale 1ns/1ps
`include "tdba_defines.svh"
module timer_dma_burst_access_tb_top;
  logic mclk;
  logic reset_n;
  logic hsel, hwrite, hreadyout, hresp, outputsForcedOff;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] chanEnable, chanOutEnable, chanOffState;
  int err_count = 0;
  int n_checks = 0;
  // device under test
  tdba_timer_dma_burst_access dut_u (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .chanEnable(chanEnable), .chanOutEnable(chanOutEnable), .chanOffState(chanOffState),
    .outputsForcedOff(outputsForcedOff));
  // bus master on the far side
  tdba_ahb_host host_u (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  // 125 mhz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, {24'h000000, a}, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    host_u.xfer(1'b0, {24'h000000, a}, 32'h00000000, q);
    chk(q, exp, msg);
    chk({31'h0, hresp}, 32'h0, "hresp");
  endtask
  // wait for outputs to follow, then compare them
  task automatic outs(input logic fo, input logic [3:0] oe, input logic [3:0] os);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, outputsForcedOff}, {31'h0, fo}, "forced off");
    chk({28'h0, chanOutEnable}, {28'h0, oe}, "out enable");
    chk({28'h0, chanOffState}, {28'h0, os}, "off state");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog well past the 150 or so cycles the tests need
  initial begin
    #50000;
    err_count++;
    end_sim();
  end
  // test sequence
  initial begin
    reset_n = 1'b0;
    chanEnable = 4'h0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`TDBA_OFF_CFG, 32'h0, "cfg reset");
    rd(`TDBA_OFF_OPT, 32'h0, "opt reset");
    wr(8'h00, 32'h0000ffff);
    rd(8'h00, 32'h0, "unmapped");
    $display("test reset done");
    // compare values written directly, then read through a burst
    for (int i = 0; i < 4; i++) wr(`TDBA_OFF_CV0 + 8'(4 * i), 32'h1000 + i);
    wr(`TDBA_OFF_CFG, 32'h0000030d); // start ch0, four registers
    rd(`TDBA_OFF_CFG, 32'h0000030d, "cfg readback");
    for (int i = 0; i < 4; i++) rd(`TDBA_OFF_BUF, 32'h1000 + i, "burst rd");
    rd(`TDBA_OFF_BUF, 32'h1000, "wrap");
    // burst write, then direct read back
    wr(`TDBA_OFF_CFG, 32'h0000030d);
    for (int i = 0; i < 4; i++) wr(`TDBA_OFF_BUF, 32'h2000 + 17 * i);
    rd(`TDBA_OFF_CFG, 32'h00000310, "reached");
    for (int i = 0; i < 4; i++) rd(`TDBA_OFF_CV0 + 8'(4 * i), 32'h2000 + 17 * i, "bw");
    // count zero: every access lands on the start register
    wr(`TDBA_OFF_CFG, 32'h0000000e);
    rd(`TDBA_OFF_BUF, 32'h2011, "count0 a");
    rd(`TDBA_OFF_BUF, 32'h2011, "count0 b");
    $display("test burst done");
    // same-value filter does not block a new value
    wr(`TDBA_OFF_OPT, 32'h00000002);
    rd(`TDBA_OFF_OPT, 32'h00000002, "opt");
    wr(`TDBA_OFF_CV0, 32'h00002000);
    wr(`TDBA_OFF_CV0, 32'h00002abc);
    rd(`TDBA_OFF_CV0, 32'h00002abc, "filtered cv");
    $display("test filter done");
    // output gating modes
    @(posedge mclk);
    chanEnable <= 4'h5;
    wr(`TDBA_OFF_CCHP, 32'h00008000);
    outs(1'b0, 4'h5, 4'h0);
    wr(`TDBA_OFF_OPT, 32'h00000001);
    wr(`TDBA_OFF_CCHP, 32'h00000000);
    outs(1'b1, 4'h0, 4'h0);
    wr(`TDBA_OFF_CCHP, 32'h00000400);
    outs(1'b0, 4'h0, 4'hf);
    wr(`TDBA_OFF_OPT, 32'h00000000);
    wr(`TDBA_OFF_CCHP, 32'h00000000);
    outs(1'b0, 4'h0, 4'h0);
    $display("test outputs done");
    end_sim();
  end
endmodule
